// ### hw/rss_sequencer.sv
// Reset and start-up sequencer: cause decode, power-up delay, oscillator
// start-up count, master clear filter and the divide-by-four clock output.
// Assumes the pin, RC tick and oscillator inputs are asynchronous to clk.
//
// Function
// RULE1: In RC mode clock_quarter_out carries oscillator divided by four.
// RULE2: Distinguish power-on, master clear running, master clear asleep, watchdog reset.
// RULE3: Never-reset registers keep value on all resets except power-on.
// RULE4: Other registers load reset state on all resets but watchdog wake-up.
// RULE5: Timeout and powerdown flags set per reset cause for software.
// RULE6: Master clear path filters and ignores short pulses.
// RULE7: Watchdog reset never pulls the master clear pin low.
// RULE8: Supply rise makes a power-on pulse that starts the time-out.
// RULE9: Power-up delay of 72 ms runs only after power-on.
// RULE10: Power-up delay counts internal RC oscillator ticks.
// RULE11: Chip stays in reset while power-up delay counts.
// RULE12: powerup_delay_enable decides whether the power-up delay runs.
// RULE13: Oscillator start-up counts 1024 crystal cycles after power-up delay.
// RULE14: Start-up count only in crystal modes after power-on or wake.
// RULE15: Power-up delay starts first, start-up count follows it.
// RULE16: RC mode without power-up delay leaves reset with no time-out.
// RULE17: Time-outs run from power-on regardless of master clear level.
// RULE18: Held master clear after time-outs starts execution on release.
// RULE19: Power-on status bit cleared on power-on, kept otherwise, software sets.
// RULE20: Power-on sets both timeout and powerdown flags to one.
// RULE21: Internal reset release is synchronous to the main clock.
// RULE22: Power-up delay is a tick counter with terminal count.
`timescale 1ns/1ps
`default_nettype none

module rss_sequencer
    import rss_pkg::*;
#(
    parameter int unsigned POWERUP_DELAY_TIMER_TICKS = PWRUP_DELAY_TICKS,
    parameter int unsigned OST_CYCLES = OSC_STARTUP_CYCLES,
    parameter int unsigned FILT_CYCLES = MASTER_CLEAR_N_FILTER_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic supply_rise,
    input wire logic master_clear_n,
    input wire logic osc_clk_in,
    input wire logic rc_tick_in,
    input wire logic watchdog_timeout,
    input wire logic sleep_req,
    input wire logic int_wake,
    input wire logic powerup_delay_enable,
    input wire logic [1:0] osc_mode,
    input wire logic por_status_set,
    output logic chip_reset,
    output logic reg_reset,
    output logic nvreg_invalid,
    output logic asleep,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic por_status,
    output logic [2:0] reset_cause,
    output logic clock_quarter_out,
    output logic master_clear_n_o,
    output logic master_clear_n_oe_n
);

    initial begin
        if (POWERUP_DELAY_TIMER_TICKS < 1 || OST_CYCLES < 1 || FILT_CYCLES < 2 || FILT_CYCLES > 255) begin
            $error("rss_sequencer: unusable parameter value");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three stages, a change counts when stages 2 and 3 agree.

    logic [2:0] master_clear_n_sync_ff, osc_sync_ff, rc_sync_ff;
    logic master_clear_n_lvl_ff, osc_lvl_ff, rc_lvl_ff;

    always_ff @(posedge clk) begin
        master_clear_n_sync_ff <= {master_clear_n_sync_ff[1:0], master_clear_n};
        osc_sync_ff <= {osc_sync_ff[1:0], osc_clk_in};
        rc_sync_ff <= {rc_sync_ff[1:0], rc_tick_in};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            master_clear_n_lvl_ff <= 1'h1;
            osc_lvl_ff <= 1'h0;
            rc_lvl_ff <= 1'h0;
        end else begin
            if (master_clear_n_sync_ff[1] == master_clear_n_sync_ff[2]) master_clear_n_lvl_ff <= master_clear_n_sync_ff[2];
            if (osc_sync_ff[1] == osc_sync_ff[2]) osc_lvl_ff <= osc_sync_ff[2];
            if (rc_sync_ff[1] == rc_sync_ff[2]) rc_lvl_ff <= rc_sync_ff[2];
        end
    end

    logic osc_prev_ff, rc_prev_ff;
    logic osc_rise, rc_rise;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            osc_prev_ff <= 1'h0;
            rc_prev_ff <= 1'h0;
        end else begin
            osc_prev_ff <= osc_lvl_ff;
            rc_prev_ff <= rc_lvl_ff;
        end
    end

    assign osc_rise = osc_lvl_ff & ~osc_prev_ff;
    assign rc_rise = rc_lvl_ff & ~rc_prev_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Master clear noise filter: a low must persist FILT_CYCLES clocks to count.
    // Longer filters reject more noise but add reset latency.

    logic [7:0] filt_cnt_ff;
    logic master_clear_n_low_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filt_cnt_ff <= 8'h00;
            master_clear_n_low_ff <= 1'h0;
        end else if (master_clear_n_lvl_ff) begin
            filt_cnt_ff <= 8'h00; // RULE6
            master_clear_n_low_ff <= 1'h0;
        end else if (filt_cnt_ff == 8'(FILT_CYCLES - 1)) begin
            master_clear_n_low_ff <= 1'h1; // RULE6
        end else begin
            filt_cnt_ff <= filt_cnt_ff + 8'h01;
        end
    end

    logic master_clear_n_low_prev_ff;
    logic master_clear_n_fall;

    always_ff @(posedge clk) begin
        if (sys_rst) master_clear_n_low_prev_ff <= 1'h0;
        else master_clear_n_low_prev_ff <= master_clear_n_low_ff;
    end

    assign master_clear_n_fall = master_clear_n_low_ff & ~master_clear_n_low_prev_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.

    function automatic logic is_crystal(input logic [1:0] m);
        return m != MODE_RC;
    endfunction

    rss_state_t state_ff;
    logic [31:0] cnt_ff;
    logic wdt_wake, wdt_rst;
    logic wake_ff, por_ff;

    assign wdt_wake = watchdog_timeout & (state_ff == ST_SLEEP);
    assign wdt_rst = watchdog_timeout & (state_ff == ST_RUN);

    // Power-on is sys_rst or the supply-rise pulse; both restart the time-outs.
    always_ff @(posedge clk) begin
        if (sys_rst || supply_rise) begin
            state_ff <= ST_POWERUP_DELAY_TIMER; // RULE8
            cnt_ff <= 32'h0;
        end else begin
            case (state_ff)
                ST_POWERUP_DELAY_TIMER: begin
                    if (!powerup_delay_enable) begin
                        state_ff <= is_crystal(osc_mode) ? ST_OST : ST_HOLD; // RULE12 RULE16
                        cnt_ff <= 32'h0;
                    end else if (rc_rise) begin
                        if (cnt_ff == POWERUP_DELAY_TIMER_TICKS - 1) begin // RULE9 RULE10 RULE22
                            state_ff <= is_crystal(osc_mode) ? ST_OST : ST_HOLD; // RULE15
                            cnt_ff <= 32'h0;
                        end else begin
                            cnt_ff <= cnt_ff + 32'h1;
                        end
                    end
                end
                ST_OST: begin
                    if (osc_rise) begin
                        if (cnt_ff == OST_CYCLES - 1) begin // RULE13
                            state_ff <= ST_HOLD;
                            cnt_ff <= 32'h0;
                        end else begin
                            cnt_ff <= cnt_ff + 32'h1;
                        end
                    end
                end
                ST_HOLD: begin
                    if (!master_clear_n_low_ff) state_ff <= ST_RUN; // RULE17 RULE18
                end
                ST_RUN: begin
                    if (master_clear_n_low_ff || wdt_rst) state_ff <= ST_HOLD; // RULE2
                    else if (sleep_req) state_ff <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (master_clear_n_low_ff) begin
                        state_ff <= ST_HOLD;
                    end else if (wdt_wake || int_wake) begin
                        state_ff <= is_crystal(osc_mode) ? ST_OST : ST_RUN; // RULE14
                        cnt_ff <= 32'h0;
                    end
                end
                default: state_ff <= ST_POWERUP_DELAY_TIMER;
            endcase
        end
    end

    assign chip_reset = (state_ff == ST_POWERUP_DELAY_TIMER) || (state_ff == ST_OST && !wake_ff)
        || (state_ff == ST_HOLD); // RULE11 RULE13 RULE21
    assign asleep = state_ff == ST_SLEEP;

    ////////////////////////////////////////////////////////////////////////////
    // Cause, flags and status; all updated on clk so release is clean.

    always_ff @(posedge clk) begin
        if (sys_rst || supply_rise) wake_ff <= 1'h0;
        else if (state_ff == ST_SLEEP && (wdt_wake || int_wake) && !master_clear_n_low_ff) wake_ff <= 1'h1;
        else if (state_ff == ST_RUN) wake_ff <= 1'h0;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || supply_rise) begin
            reset_cause <= CAUSE_POR; // RULE2
            timeout_flag_n <= FLAG_RST; // RULE20
            powerdown_flag_n <= FLAG_RST; // RULE20
        end else if (state_ff == ST_RUN && master_clear_n_low_ff) begin
            reset_cause <= CAUSE_MASTER_CLEAR_N_RUN; // RULE5
        end else if (wdt_rst) begin
            reset_cause <= CAUSE_WDT_RESET;
            timeout_flag_n <= 1'h0; // RULE5
            powerdown_flag_n <= 1'h1;
        end else if (state_ff == ST_SLEEP && master_clear_n_low_ff) begin
            reset_cause <= CAUSE_MASTER_CLEAR_N_SLEEP;
            timeout_flag_n <= 1'h1; // RULE5
            powerdown_flag_n <= 1'h0;
        end else if (wdt_wake) begin
            reset_cause <= CAUSE_WDT_WAKE;
            timeout_flag_n <= 1'h0; // RULE5
            powerdown_flag_n <= 1'h0;
        end else if (state_ff == ST_SLEEP && int_wake) begin
            reset_cause <= CAUSE_INT_WAKE;
            timeout_flag_n <= 1'h1;
            powerdown_flag_n <= 1'h0;
        end
    end

    // The power-on clear wins over a software set in the same cycle.
    always_ff @(posedge clk) begin
        if (sys_rst || supply_rise) begin
            por_ff <= 1'h1; // RULE3
            por_status <= PORBIT_RST;
        end else begin
            por_ff <= 1'h0;
            if (por_status_set) por_status <= 1'h1; // RULE19
        end
    end

    // Register reset strobes: wake-ups leave the defined-state registers alone.
    assign reg_reset = chip_reset && !wake_ff; // RULE4
    assign nvreg_invalid = (state_ff == ST_POWERUP_DELAY_TIMER) || por_ff; // RULE3

    ////////////////////////////////////////////////////////////////////////////
    // Divide-by-four clock output, only in RC mode.

    logic [1:0] div_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) div_ff <= DIV4_RST;
        else if (osc_rise) div_ff <= div_ff + 2'h1;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) clock_quarter_out <= 1'h0;
        else clock_quarter_out <= (osc_mode == MODE_RC) & div_ff[1]; // RULE1
    end

    // The pin is an input only; watchdog resets never drive it.
    assign master_clear_n_o = 1'h1; // RULE7
    assign master_clear_n_oe_n = 1'h1; // RULE7

endmodule : rss_sequencer

`default_nettype wire

// ### include/rss_pkg.sv
// Constants and types for the reset and start-up sequencer.
// Assumes a 100 MHz system clock and a slow internal RC tick input.
package rss_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned PWRUP_DELAY_MS = 72;
    localparam int unsigned RC_TICK_KHZ = 32;
    localparam int unsigned PWRUP_DELAY_TICKS = PWRUP_DELAY_MS * RC_TICK_KHZ;
    localparam int unsigned OSC_STARTUP_CYCLES = 1024;
    localparam int unsigned MASTER_CLEAR_N_FILTER_CYCLES = 8;
    localparam logic [1:0] DIV4_RST = 2'h0;
    localparam logic PORBIT_RST = 1'h0;
    localparam logic FLAG_RST = 1'h1;

    typedef enum logic [1:0] {
        MODE_LP = 2'h0,
        MODE_XT = 2'h1,
        MODE_HS = 2'h2,
        MODE_RC = 2'h3
    } rss_osc_mode_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_POWERUP_DELAY_TIMER = 3'h1,
        ST_OST = 3'h3,
        ST_HOLD = 3'h2,
        ST_SLEEP = 3'h4
    } rss_state_t;

    typedef enum logic [2:0] {
        CAUSE_POR = 3'h0,
        CAUSE_MASTER_CLEAR_N_RUN = 3'h1,
        CAUSE_MASTER_CLEAR_N_SLEEP = 3'h2,
        CAUSE_WDT_RESET = 3'h3,
        CAUSE_WDT_WAKE = 3'h4,
        CAUSE_INT_WAKE = 3'h5
    } rss_cause_t;
endpackage : rss_pkg

// ### dv/rss_seq_properties.sv
// Port checker for the reset and start-up sequencer.
// Assumes one clk domain and the synchronous reset sys_rst.
`timescale 1ns/1ps
`default_nettype none
module rss_seq_properties
    import rss_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic supply_rise,
    input wire logic master_clear_n,
    input wire logic watchdog_timeout,
    input wire logic powerup_delay_enable,
    input wire logic [1:0] osc_mode,
    input wire logic por_status_set,
    input wire logic chip_reset,
    input wire logic reg_reset,
    input wire logic asleep,
    input wire logic timeout_flag_n,
    input wire logic powerdown_flag_n,
    input wire logic por_status,
    input wire logic [2:0] reset_cause,
    input wire logic clock_quarter_out,
    input wire logic master_clear_n_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    sequence rc_por_s;
        supply_rise && osc_mode == 2'h3 && !powerup_delay_enable && master_clear_n;
    endsequence
    sequence wdt_run_s;
        watchdog_timeout && !asleep && !chip_reset;
    endsequence
    pin_undriven_a: assert property (master_clear_n_oe_n) else $error("pin driven");
    por_flags_a: assert property (supply_rise |=> chip_reset && timeout_flag_n
        && powerdown_flag_n && !por_status && reset_cause == 3'h0) else $error("por state");
    powerup_delay_timer_holds_a: assert property (supply_rise && powerup_delay_enable |=> chip_reset[*3])
        else $error("early release");
    rc_no_timeout_a: assert property (rc_por_s |-> ##[1:30] !chip_reset)
        else $error("rc slow release");
    reg_reset_only_a: assert property (reg_reset |-> chip_reset) else $error("reg reset");
    por_regs_a: assert property (supply_rise |=> reg_reset) else $error("no reg reset");
    wake_regs_a: assert property (asleep && watchdog_timeout && master_clear_n |=> !reg_reset)
        else $error("wake reset regs");
    quarter_idle_a: assert property ((osc_mode != 2'h3)[*2] |-> !clock_quarter_out)
        else $error("quarter active");
    por_bit_keep_a: assert property ((por_status || por_status_set) && !supply_rise
        |=> por_status) else $error("por bit lost");
    wdt_reset_flags_a: assert property (wdt_run_s |-> ##[1:4] (!timeout_flag_n
        && powerdown_flag_n && reset_cause == 3'h3)) else $error("wdt reset flags");
    wdt_wake_flags_a: assert property (asleep && watchdog_timeout |-> ##[1:4]
        (!timeout_flag_n && !powerdown_flag_n && reset_cause == 3'h4)) else $error("wake");
endmodule : rss_seq_properties
bind rss_sequencer rss_seq_properties rss_seq_properties_inst (.clk(clk), .sys_rst(sys_rst),
    .supply_rise(supply_rise), .master_clear_n(master_clear_n),
    .watchdog_timeout(watchdog_timeout), .powerup_delay_enable(powerup_delay_enable),
    .osc_mode(osc_mode), .por_status_set(por_status_set), .chip_reset(chip_reset),
    .reg_reset(reg_reset), .asleep(asleep), .timeout_flag_n(timeout_flag_n),
    .powerdown_flag_n(powerdown_flag_n), .por_status(por_status), .reset_cause(reset_cause),
    .clock_quarter_out(clock_quarter_out), .master_clear_n_oe_n(master_clear_n_oe_n));
`default_nettype wire

// ### dv/rss_far_side.sv
// Model of the pin, crystal and internal RC oscillator beside the sequencer.
// Assumes the bench reads the edge counters to judge the time-outs.
`timescale 1ns/1ps
`default_nettype none
module rss_far_side (
    input wire logic pin_low,
    output logic osc_clk_in,
    output logic rc_tick_in,
    output logic master_clear_n,
    output int osc_n,
    output int rc_n
);
    // Both oscillators run free, far slower than clk, so every edge survives sync.
    initial begin
        osc_clk_in = 1'h0;
        rc_tick_in = 1'h0;
        osc_n = 0;
        rc_n = 0;
    end
    always #40 osc_clk_in = ~osc_clk_in;
    always #200 rc_tick_in = ~rc_tick_in;
    always @(posedge osc_clk_in) osc_n++;
    always @(posedge rc_tick_in) rc_n++;
    // The pin has a pull-up, so a release returns it high at once.
    assign master_clear_n = pin_low ? 1'h0 : 1'h1;
endmodule : rss_far_side
`default_nettype wire

// ### dv/tb_reset_startup_sequencer.sv
// Self-checking bench for the reset and start-up sequencer.
// Assumes short time-out parameters and the far-side model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_reset_startup_sequencer;
    import rss_pkg::*;
    logic clk = 0, sys_rst = 1, supply_rise = 0, watchdog_timeout = 0, sleep_req = 0;
    logic powerup_delay_enable = 1, por_status_set = 0, pin_low = 0, int_wake = 0;
    logic [1:0] osc_mode = 2'h1;
    logic osc_clk_in, rc_tick_in, master_clear_n, chip_reset, asleep, tf_n, pf_n, por_status;
    logic [2:0] reset_cause;
    logic cq, oe_n, mo, reg_reset, nvreg_invalid;
    int osc_n, rc_n, rc0, osc0, failures = 0, n_checks = 0;
    always #5 clk = ~clk;
    rss_far_side rss_far_side_inst (.pin_low(pin_low), .osc_clk_in(osc_clk_in),
        .rc_tick_in(rc_tick_in), .master_clear_n(master_clear_n), .osc_n(osc_n), .rc_n(rc_n));
    rss_sequencer #(.POWERUP_DELAY_TIMER_TICKS(4), .OST_CYCLES(4), .FILT_CYCLES(8)) rss_sequencer_inst (
        .clk(clk), .sys_rst(sys_rst), .supply_rise(supply_rise), .master_clear_n(master_clear_n),
        .osc_clk_in(osc_clk_in), .rc_tick_in(rc_tick_in), .watchdog_timeout(watchdog_timeout),
        .sleep_req(sleep_req), .int_wake(int_wake), .powerup_delay_enable(powerup_delay_enable),
        .osc_mode(osc_mode), .por_status_set(por_status_set), .chip_reset(chip_reset),
        .reg_reset(reg_reset), .nvreg_invalid(nvreg_invalid),
        .asleep(asleep), .timeout_flag_n(tf_n),
        .powerdown_flag_n(pf_n), .por_status(por_status), .reset_cause(reset_cause),
        .clock_quarter_out(cq), .master_clear_n_o(mo), .master_clear_n_oe_n(oe_n));
    ////////////////////////////////////////////////////////////////////////////////
    task results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task wait_rst(input logic lvl, input int bound);
        for (int i = 0; i < bound && chip_reset !== lvl; i++) step(1);
        `CHK("chip_reset wait", lvl, chip_reset)
        if (chip_reset !== lvl) results();
    endtask : wait_rst
    task pulse_wdt();
        watchdog_timeout = 1;
        step(1);
        watchdog_timeout = 0;
        step(3);
    endtask : pulse_wdt
    // Snapshot early: an edge just before power-on still reaches the counters.
    task por(input logic [1:0] m, input logic en);
        rc0 = rc_n;
        osc0 = osc_n;
        osc_mode = m;
        powerup_delay_enable = en;
        step(5);
        supply_rise = 1;
        step(1);
        supply_rise = 0;
    endtask : por
    ////////////////////////////////////////////////////////////////////////////////
    task t_crystal();
        for (int m = 0; m < 3; m++) for (int e = 0; e < 2; e++) begin
            por(m[1:0], e[0]);
            `CHK("por regs", 1'h1, reg_reset)
            `CHK("por nvreg", 1'h1, nvreg_invalid)
            wait_rst(1'h0, 3000);
            `CHK("nvreg valid", 1'h0, nvreg_invalid)
            `CHK("powerup_delay_timer ran", e[0], (rc_n - rc0) >= 4)
            `CHK("ost ran", 1'h1, (osc_n - osc0) >= 4)
            `CHK("por flags", 2'h3, {tf_n, pf_n})
        end
        $display("t_crystal done");
    endtask : t_crystal
    task t_hold();
        pin_low = 1;
        por(2'h1, 1'h1);
        step(400);
        `CHK("held", 1'h1, chip_reset)
        pin_low = 0;
        wait_rst(1'h0, 20);
        $display("t_hold done");
    endtask : t_hold
    task t_int();
        sleep_req = 1;
        step(1);
        sleep_req = 0;
        step(2);
        int_wake = 1;
        step(1);
        int_wake = 0;
        step(2);
        `CHK("int cause", 3'h5, reset_cause)
        `CHK("int flags", 2'h2, {tf_n, pf_n})
        `CHK("int regs", 1'h0, reg_reset)
        step(100);
        $display("t_int done");
    endtask : t_int
    task t_wdt();
        por_status_set = 1;
        step(1);
        por_status_set = 0;
        pulse_wdt();
        wait_rst(1'h0, 50);
        `CHK("wdt cause", 3'h3, reset_cause)
        `CHK("wdt flags", 2'h1, {tf_n, pf_n})
        `CHK("por bit", 1'h1, por_status)
        `CHK("pin enable", 1'h1, oe_n)
        `CHK("pin level", 1'h1, mo)
        `CHK("nvreg kept", 1'h0, nvreg_invalid)
        sleep_req = 1;
        step(1);
        sleep_req = 0;
        step(2);
        `CHK("asleep", 1'h1, asleep)
        pulse_wdt();
        `CHK("wake cause", 3'h4, reset_cause)
        `CHK("wake flags", 2'h0, {tf_n, pf_n})
        `CHK("wake regs", 1'h0, reg_reset)
        step(100);
        sleep_req = 1;
        step(1);
        sleep_req = 0;
        step(2);
        pin_low = 1;
        wait_rst(1'h1, 30);
        `CHK("sleep regs", 1'h1, reg_reset)
        pin_low = 0;
        wait_rst(1'h0, 50);
        `CHK("sleep master_clear_n cause", 3'h2, reset_cause)
        `CHK("sleep master_clear_n flags", 2'h2, {tf_n, pf_n})
        $display("t_wdt done");
    endtask : t_wdt
    task t_master_clear_n();
        logic saw;
        saw = 0;
        pin_low = 1;
        step(4);
        pin_low = 0;
        repeat (20) begin
            step(1);
            saw = saw | chip_reset;
        end
        `CHK("short pulse", 1'h0, saw)
        pin_low = 1;
        wait_rst(1'h1, 30);
        pin_low = 0;
        wait_rst(1'h0, 30);
        `CHK("master_clear_n cause", 3'h1, reset_cause)
        `CHK("master_clear_n flags", 2'h2, {tf_n, pf_n})
        $display("t_master_clear_n done");
    endtask : t_master_clear_n
    task t_rc();
        int n;
        logic prev;
        n = 0;
        por(2'h3, 1'h0);
        wait_rst(1'h0, 30);
        prev = cq;
        repeat (160) begin
            step(1);
            if (cq === 1'h1 && prev === 1'h0) n++;
            prev = cq;
        end
        `CHK("quarter rate", 1'h1, n >= 4 && n <= 6)
        $display("t_rc done");
    endtask : t_rc
    initial begin
        step(5);
        sys_rst = 0;
        t_crystal();
        t_hold();
        t_int();
        t_wdt();
        t_master_clear_n();
        t_rc();
        results();
    end
endmodule : tb_reset_startup_sequencer
`default_nettype wire
